// file: logic/sdsp_regs.svh
// Purpose: Constants for the serial debug slave port.
// Assumes: Included by its bare name.
// Notes:   Command codes and word sizes of the serial frame.
`ifndef SDSP_REGS_SVH
`define SDSP_REGS_SVH
`define SDSP_CMD_WIDTH    8
`define SDSP_WORD_WIDTH   16
`define SDSP_CMD_WRITE    8'h02
`define SDSP_CMD_READ     8'h03
`define SDSP_CMD_LAST_BIT 5'h07
`define SDSP_WORD_LAST_BIT 5'h0F
`endif

// file: logic/sdsp_pkg.sv
// Purpose: Types for the serial debug slave port.
// Assumes: Nothing.
// Notes:   Frame phases of one transaction.
package sdsp_pkg;
   typedef enum logic [2:0] {
      SDSP_CMD   = 3'b000,
      SDSP_ADDR  = 3'b001,
      SDSP_WDATA = 3'b010,
      SDSP_CHECK = 3'b011,
      SDSP_RDATA = 3'b100,
      SDSP_IGNORE = 3'b101
   } sdsp_phase_e;
endpackage

// file: logic/sdsp_sync.sv
// Purpose: Two-flop synchroniser with edge detection for serial pins.
// Assumes: Inputs come from outside the clock domain.
// Notes:   Edges are found on the second flop against a third history flop.
`timescale 1ns/1ns
`default_nettype none
module sdsp_sync #(
   parameter logic RESET_LEVEL = 1'b0
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic sys_rst,
   // Pin in
   input  wire logic pin_in,
   // Synchronised view
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta_r;
   logic sync_r;
   logic hist_r;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         meta_r <= RESET_LEVEL;
         sync_r <= RESET_LEVEL;
         hist_r <= RESET_LEVEL;
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         hist_r <= sync_r;
      end
   end

   // Resetting to the pin's idle level keeps a false edge or a false select from following reset.
   assign level = sync_r;
   assign rise  = sync_r & ~hist_r;
   assign fall  = ~sync_r & hist_r;
endmodule
`default_nettype wire

// file: logic/sdsp_slave.sv
// Purpose: Serial debug slave port giving word access to a 16-bit address space.
// Assumes: Serial clock well below a quarter of the system clock; memory read data valid one cycle after mem_rd.
// Notes:   All serial input pins are oversampled; a deselect clears phase, bit count and the input shifter, but not cmd_r, addr_r or shift_out_r.
//
// Behaviour
// - First eight bits are the command
// - Next sixteen bits are start address
// - Then sixteen-bit data words move
// - Sample data input on serial rising edge
// - Change data output on serial falling edge
// - Select high ends transaction, drops partials
// - Each further word increments the address
// - Command 02 writes consecutive words
// - Command 03 reads consecutive words
// - Reads send check word before data
// - Check word is command and address high
// - Idle output low running, high stopped
// - Works with processor running or halted
`timescale 1ns/1ns
`default_nettype none
`include "sdsp_regs.svh"
module sdsp_slave (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // Serial pins
   input  wire logic        ser_clk,
   input  wire logic        ser_sel_n,
   input  wire logic        ser_din,
   output logic             ser_dout,
   // Processor state
   input  wire logic        cpu_halted,
   // Memory port
   output logic             mem_wr,
   output logic             mem_rd,
   output logic [15:0]      mem_addr,
   output logic [15:0]      mem_wdata,
   input  wire logic [15:0] mem_rdata
);
   localparam int W = `SDSP_WORD_WIDTH;

   logic sclk_rise;
   logic sclk_fall;
   logic sel_n_lvl;
   logic din_lvl;
   logic halted_lvl;

   sdsp_sync #(.RESET_LEVEL(1'b0)) u_clk (
      .clock       (clock),
      .sys_rst     (sys_rst),
      .pin_in      (ser_clk),
      .level       (),
      .rise        (sclk_rise),
      .fall        (sclk_fall)
   );
   sdsp_sync #(.RESET_LEVEL(1'b1)) u_sel (
      .clock       (clock),
      .sys_rst     (sys_rst),
      .pin_in      (ser_sel_n),
      .level       (sel_n_lvl),
      .rise        (),
      .fall        ()
   );
   sdsp_sync #(.RESET_LEVEL(1'b0)) u_din (
      .clock       (clock),
      .sys_rst     (sys_rst),
      .pin_in      (ser_din),
      .level       (din_lvl),
      .rise        (),
      .fall        ()
   );
   sdsp_sync #(.RESET_LEVEL(1'b0)) u_halt (
      .clock       (clock),
      .sys_rst     (sys_rst),
      .pin_in      (cpu_halted),
      .level       (halted_lvl),
      .rise        (),
      .fall        ()
   );

   sdsp_pkg::sdsp_phase_e phase_r;
   logic [4:0]   bit_cnt_r;
   logic [W-1:0] shift_in_r;
   logic [W-1:0] shift_out_r;
   logic [7:0]   cmd_r;
   logic [15:0]  addr_r;
   logic         load_pend_r;
   logic         first_out_r;

   wire active   = ~sel_n_lvl;
   wire samp     = active & sclk_rise;
   wire [W-1:0] in_word = {shift_in_r[W-2:0], din_lvl};
   wire cmd_done = samp & (phase_r == sdsp_pkg::SDSP_CMD) & (bit_cnt_r == `SDSP_CMD_LAST_BIT);
   wire word_end = samp & (phase_r != sdsp_pkg::SDSP_CMD) & (bit_cnt_r == `SDSP_WORD_LAST_BIT);

   // Bit counter and input shifter; a high select clears the bit count and the partial input word.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         bit_cnt_r  <= 5'h00;
         shift_in_r <= 16'h0000;
      end else if (!active) begin
         bit_cnt_r  <= 5'h00;
         shift_in_r <= 16'h0000;
      end else if (samp) begin
         shift_in_r <= in_word;
         bit_cnt_r  <= (cmd_done | word_end) ? 5'h00 : bit_cnt_r + 5'h01;
      end
   end

   // Frame phase sequencing.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         phase_r <= sdsp_pkg::SDSP_CMD;
      end else if (!active) begin
         phase_r <= sdsp_pkg::SDSP_CMD;
      end else if (cmd_done) begin
         phase_r <= sdsp_pkg::SDSP_ADDR;
      end else if (word_end) begin
         case (phase_r)
            sdsp_pkg::SDSP_ADDR: begin
               if (cmd_r == `SDSP_CMD_WRITE) begin
                  phase_r <= sdsp_pkg::SDSP_WDATA;
               end else if (cmd_r == `SDSP_CMD_READ) begin
                  phase_r <= sdsp_pkg::SDSP_CHECK;
               end else begin
                  phase_r <= sdsp_pkg::SDSP_IGNORE;
               end
            end
            sdsp_pkg::SDSP_CHECK: phase_r <= sdsp_pkg::SDSP_RDATA;
            default:              phase_r <= phase_r;
         endcase
      end
   end

   // Command and address capture with auto-increment.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_r  <= 8'h00;
         addr_r <= 16'h0000;
      end else if (cmd_done) begin
         cmd_r <= in_word[7:0];
      end else if (word_end) begin
         if (phase_r == sdsp_pkg::SDSP_ADDR) begin
            addr_r <= in_word;
         end else if (phase_r == sdsp_pkg::SDSP_WDATA || phase_r == sdsp_pkg::SDSP_RDATA) begin
            addr_r <= addr_r + 16'h0001;
         end
      end
   end

   // Memory strobes: write on each full received write-data word, read ahead of each outgoing data word.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mem_wr    <= 1'b0;
         mem_rd    <= 1'b0;
         mem_addr  <= 16'h0000;
         mem_wdata <= 16'h0000;
      end else begin
         mem_wr <= word_end & (phase_r == sdsp_pkg::SDSP_WDATA);
         mem_rd <= 1'b0;
         if (word_end && phase_r == sdsp_pkg::SDSP_WDATA) begin
            mem_addr  <= addr_r;
            mem_wdata <= in_word;
         end else if (word_end && (phase_r == sdsp_pkg::SDSP_CHECK || phase_r == sdsp_pkg::SDSP_RDATA)) begin
            // The next word is fetched during the high half of the current word's last clock.
            mem_rd   <= 1'b1;
            mem_addr <= (phase_r == sdsp_pkg::SDSP_CHECK) ? addr_r : addr_r + 16'h0001;
         end
      end
   end

   // Output shifter; new bits appear only on falling serial edges.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         shift_out_r <= 16'h0000;
         load_pend_r <= 1'b0;
         first_out_r <= 1'b0;
      end else if (!active) begin
         load_pend_r <= 1'b0;
         first_out_r <= 1'b0;
      end else begin
         load_pend_r <= mem_rd;
         if (word_end && phase_r == sdsp_pkg::SDSP_ADDR && cmd_r == `SDSP_CMD_READ) begin
            shift_out_r <= {cmd_r, in_word[15:8]};
            first_out_r <= 1'b1;
         end else if (load_pend_r) begin
            shift_out_r <= mem_rdata;
            first_out_r <= 1'b1;
         end else if (active && sclk_fall) begin
            // First fall of a word presents the MSB; later falls shift.
            if (first_out_r) begin
               first_out_r <= 1'b0;
            end else begin
               shift_out_r <= {shift_out_r[W-2:0], 1'b0};
            end
         end
      end
   end

   // Data output pin, driven at all times.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ser_dout <= 1'b0;
      end else if (!active || phase_r == sdsp_pkg::SDSP_CMD || phase_r == sdsp_pkg::SDSP_ADDR
                   || phase_r == sdsp_pkg::SDSP_WDATA || phase_r == sdsp_pkg::SDSP_IGNORE) begin
         ser_dout <= halted_lvl;
      end else if (sclk_fall) begin
         ser_dout <= first_out_r ? shift_out_r[W-1] : shift_out_r[W-2];
      end
   end
endmodule
`default_nettype wire

// file: testbench/sdsp_properties.sv
// Purpose: Assertions on the serial debug slave port pins.
// Assumes: cpu_halted is held steady while the port is selected.
// Notes:   Bound to every sdsp_slave instance.
`timescale 1ns/1ns
`default_nettype none
module sdsp_properties (
   // Clock and reset
   input wire logic        clock,
   input wire logic        sys_rst,
   // Serial side
   input wire logic        ser_clk,
   input wire logic        ser_sel_n,
   input wire logic        ser_dout,
   input wire logic        cpu_halted,
   // Memory side
   input wire logic        mem_wr,
   input wire logic        mem_rd,
   input wire logic [15:0] mem_addr
);
   logic [15:0] last_addr_r;
   logic        seen_r;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // A deselect forgets the chain, so a new frame may start anywhere.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         last_addr_r <= 16'h0000;
         seen_r <= 1'b0;
      end else if (ser_sel_n) begin
         seen_r <= 1'b0;
      end else if (mem_wr || mem_rd) begin
         last_addr_r <= mem_addr;
         seen_r <= 1'b1;
      end
   end
   a_wr_single_pulse: assert property (mem_wr |=> !mem_wr [*8])
      else $error("write strobe repeated too soon");
   a_rd_single_pulse: assert property (mem_rd |=> !mem_rd [*8])
      else $error("read strobe repeated too soon");
   a_idle_running: assert property ((ser_sel_n && !cpu_halted) [*8] |-> !ser_dout)
      else $error("idle output not low");
   a_idle_halted: assert property ((ser_sel_n && cpu_halted) [*8] |-> ser_dout)
      else $error("idle output not high");
   a_dout_on_fall: assert property ($changed(ser_dout) && !ser_sel_n && !$past(ser_sel_n, 6)
      |-> !$past(ser_clk, 2))
      else $error("output changed away from a falling edge");
   a_addr_step_one: assert property ((mem_wr || mem_rd) && seen_r
      |-> mem_addr == last_addr_r + 16'h0001)
      else $error("address did not step by one");
   a_write_dout_idle: assert property (mem_wr |-> ser_dout == cpu_halted)
      else $error("output left idle level during write");
   a_strobe_in_frame: assert property ((mem_wr || mem_rd) |-> !$past(ser_sel_n, 4))
      else $error("memory strobe outside a frame");
   cover property (mem_wr && seen_r);
   cover property (mem_rd && seen_r);
   cover property (!ser_sel_n && $fell(ser_dout));
endmodule
bind sdsp_slave sdsp_properties sdsp_properties_inst (.clock(clock), .sys_rst(sys_rst), .ser_clk(ser_clk),
   .ser_sel_n(ser_sel_n), .ser_dout(ser_dout), .cpu_halted(cpu_halted), .mem_wr(mem_wr), .mem_rd(mem_rd),
   .mem_addr(mem_addr));
`default_nettype wire

// file: testbench/sdsp_master.sv
// Purpose: Serial master model driving the debug slave pins.
// Assumes: 400 ns serial clock, eight system clocks a bit.
// Notes:   Serial clock rests low between frames.
`timescale 1ns/1ns
`default_nettype none
module sdsp_master (
   // Clock
   input wire logic clock,
   // Serial pins
   input wire logic ser_dout,
   output var logic ser_clk = 1'b0,
   output var logic ser_sel_n = 1'b1,
   output var logic ser_din = 1'b0
);
   task automatic half();
      repeat (4) @(negedge clock);
   endtask
   // The reply is taken at our own rising edge, as a real master would.
   task automatic bit1(input logic b, output logic o);
      ser_din = b;
      half();
      ser_clk = 1'b1;
      o = ser_dout;
      half();
      ser_clk = 1'b0;
   endtask
   task automatic open_frame(input logic [7:0] cmd, input logic [15:0] addr);
      logic o;
      ser_sel_n = 1'b1;
      repeat (2) bit1(~ser_din, o);
      ser_sel_n = 1'b0;
      for (int i = 7; i >= 0; i--) bit1(cmd[i], o);
      for (int i = 15; i >= 0; i--) bit1(addr[i], o);
   endtask
   task automatic word(input logic [15:0] v, output logic [15:0] got);
      for (int i = 15; i >= 0; i--) bit1(v[i], got[i]);
   endtask
   task automatic close_frame();
      half();
      ser_sel_n = 1'b1;
      ser_din = ~ser_din;
      // A pause here keeps the next frame from driving the data pin again in this time step.
      half();
   endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: Self-checking bench for the serial debug slave port.
// Assumes: The master model owns the serial pins; the bench owns memory.
// Notes:   Inputs move on falling clock edges.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic             clock = 1'b0;
   logic             sys_rst = 1'b1;
   logic             cpu_halted = 1'b0;
   logic [15:0]      mem_rdata = 16'h0000;
   logic [15:0]      mem [0:65535];
   logic [15:0]      got;
   wire logic        ser_clk, ser_sel_n, ser_din, ser_dout, mem_wr, mem_rd;
   wire logic [15:0] mem_addr, mem_wdata;
   int               fails = 0;
   int               n_compared = 0;
   int               n_strobe = 0;
   int               cycles = 0;
   always #25 clock = ~clock;
   sdsp_slave sdsp_slave_inst (.clock(clock), .sys_rst(sys_rst), .ser_clk(ser_clk), .ser_sel_n(ser_sel_n),
      .ser_din(ser_din), .ser_dout(ser_dout), .cpu_halted(cpu_halted), .mem_wr(mem_wr), .mem_rd(mem_rd),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   // The data output has this one listener only, since it is driven while deselected.
   sdsp_master sdsp_master_inst (.clock(clock), .ser_dout(ser_dout), .ser_clk(ser_clk),
      .ser_sel_n(ser_sel_n), .ser_din(ser_din));
   // Read data is ready at the falling edge inside the strobe cycle, half a cycle after the strobe.
   always @(negedge clock) begin
      if (mem_wr) mem[mem_addr] <= mem_wdata;
      if (mem_rd) mem_rdata <= mem[mem_addr];
   end
   // Strobes are counted on the falling edge, where the registered outputs are settled.
   always @(negedge clock) begin
      if (mem_wr || mem_rd) n_strobe++;
      cycles++;
      if (cycles == 20000) begin
         fails++;
         give_verdict();
      end
   end
   task automatic check(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("ERROR at %0t ns: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic t_idle();
      cpu_halted = 1'b0;
      repeat (10) @(negedge clock);
      check({15'h0000, ser_dout}, 16'h0000);
      cpu_halted = 1'b1;
      repeat (10) @(negedge clock);
      check({15'h0000, ser_dout}, 16'h0001);
      $display("idle level test done");
   endtask
   task automatic t_write();
      cpu_halted = 1'b0;
      sdsp_master_inst.open_frame(8'h02, 16'hFFFE);
      for (int i = 0; i < 3; i++) sdsp_master_inst.word(16'hC0DE + 16'(i), got);
      sdsp_master_inst.close_frame();
      repeat (8) @(negedge clock);
      check(mem[16'hFFFE], 16'hC0DE);
      check(mem[16'hFFFF], 16'hC0DF);
      check(mem[16'h0000], 16'hC0E0);
      $display("write test done");
   endtask
   task automatic t_read();
      cpu_halted = 1'b1;
      sdsp_master_inst.open_frame(8'h03, 16'hFFFF);
      sdsp_master_inst.word(16'h0000, got);
      check(got, 16'h03FF);
      sdsp_master_inst.word(16'h0000, got);
      check(got, 16'hC0DF);
      sdsp_master_inst.word(16'h0000, got);
      check(got, 16'hC0E0);
      sdsp_master_inst.close_frame();
      $display("read test done");
   endtask
   task automatic t_abort();
      logic o;
      cpu_halted = 1'b0;
      sdsp_master_inst.open_frame(8'h02, 16'h0100);
      sdsp_master_inst.word(16'h1111, got);
      for (int i = 0; i < 8; i++) sdsp_master_inst.bit1(1'b1, o);
      sdsp_master_inst.close_frame();
      repeat (8) @(negedge clock);
      check(mem[16'h0100], 16'h1111);
      check(mem[16'h0101], 16'hFEFE);
      $display("abort test done");
   endtask
   task automatic t_other();
      int s0;
      cpu_halted = 1'b1;
      s0 = n_strobe;
      sdsp_master_inst.open_frame(8'h05, 16'h0200);
      sdsp_master_inst.word(16'h5555, got);
      check(got, 16'hFFFF);
      sdsp_master_inst.close_frame();
      repeat (8) @(negedge clock);
      check(16'(n_strobe - s0), 16'h0000);
      $display("unknown command test done");
   endtask
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = ~16'(i);
      repeat (20) @(negedge clock);
      sys_rst = 1'b0;
      t_idle();
      t_write();
      t_read();
      t_abort();
      t_other();
      give_verdict();
   end
endmodule
`default_nettype wire
